// ==== core/ssr_pkg.sv ====
// Constants and carrier types for the sync serial register slice
package ssr_pkg;

  // ***************************************************************
  // Register byte addresses
  // ***************************************************************
  localparam logic [31:0] ADDR_TX_HOLD   = 32'hF001_0024;
  localparam logic [31:0] ADDR_RX_SYNC   = 32'hF001_0030;
  localparam logic [31:0] ADDR_TX_SYNC   = 32'hF001_0034;
  localparam logic [31:0] ADDR_CMP_ZERO  = 32'hF001_0038;
  localparam logic [31:0] ADDR_CMP_ONE   = 32'hF001_003C;
  localparam logic [31:0] ADDR_STATUS    = 32'hF001_0040;
  localparam logic [31:0] ADDR_IRQ_SET   = 32'hF001_0044;
  localparam logic [31:0] ADDR_IRQ_CLR   = 32'hF001_0048;
  localparam logic [31:0] ADDR_IRQ_MASK  = 32'hF001_004C;
  localparam logic [31:0] ADDR_WP_MODE   = 32'hF001_00E4;

  // ***************************************************************
  // Status and mask bit positions
  // ***************************************************************
  localparam int unsigned BIT_TX_FREE    = 0;
  localparam int unsigned BIT_TX_SENT    = 1;
  localparam int unsigned BIT_RX_AVAIL   = 4;
  localparam int unsigned BIT_RX_OVWR    = 5;
  localparam int unsigned BIT_CMP_ZERO   = 8;
  localparam int unsigned BIT_CMP_ONE    = 9;
  localparam int unsigned BIT_TX_SYNC    = 10;
  localparam int unsigned BIT_RX_SYNC    = 11;
  localparam int unsigned BIT_TX_ACTIVE  = 16;
  localparam int unsigned BIT_RX_ACTIVE  = 17;
  localparam logic [31:0] SRC_MASK       = 32'h0000_0F33;

  // ***************************************************************
  // Field layouts and reset values
  // ***************************************************************
  localparam int unsigned SYNC_W         = 16;
  localparam int unsigned WP_KEY_LSB     = 8;
  localparam int unsigned WP_ON_BIT      = 0;
  localparam logic [23:0] WP_KEY         = 24'h53_5343;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [15:0] RST_HALF       = 16'h0000;
  localparam logic [4:0]  RST_CNT        = 5'h00;

  // Transmit framing configuration from the mode registers
  typedef struct packed {
    logic       sync_pattern_send_enable;
    logic [3:0] sync_len;
    logic [4:0] word_length_field;
  } ssr_tx_cfg_t;

  // Receive engine events, all on the peripheral clock
  typedef struct packed {
    logic        word_valid;
    logic [31:0] word;
    logic        holding_read;
    logic        sync_valid;
    logic [15:0] sync_word;
    logic        sync_event;
  } ssr_rx_evt_t;

endpackage : ssr_pkg

// ==== core/ssr_regs.sv ====
// Register slice, status flags, mask and transmit shifter
//
// What this block does
// RQ1: Transmit words come from a write-only holding word, bit 0 first.
// RQ2: Received sync data reads in bits 15..0, upper bits zero.
// RQ3: Transmit sync word is a read/write 16-bit field.
// RQ4: Two 16-bit receive compare words in separate registers.
// RQ5: Compare writes are ignored while write protection is on.
// RQ6: Status bit 0 is 1 when the holding word is empty.
// RQ7: Status bit 1 is 1 when holding and shifter are drained.
// RQ8: Status bit 4 is 1 while a received word waits.
// RQ9: Status bit 5 sets on receive overwrite, clears on read.
// RQ10: Status bits 8, 9 set on compare match, clear on read.
// RQ11: Status bits 10, 11 set on sync events, clear on read.
// RQ12: Status bits 16, 17 show live transmit and receive enables.
// RQ13: Ones written to the enable register set mask bits.
// RQ14: Ones written to the disable register clear mask bits.
// RQ15: Mask register reads enabled sources.
// RQ16: Sources sit at bits 0,1,4,5,8..11 in all three.
// RQ17: With sync send on, the sync word shifts out in frame sync.
// RQ18: Write protection changes only with the matching key.
// RQ19: Interrupt is high while a flag and its mask bit are 1.
// RQ20: Write-only reads give zero, read-only writes are ignored.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module ssr_regs (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [31:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Engine side
  input  wire logic                tx_active_status_i,
  input  wire logic                rx_active_status_i,
  input  wire ssr_pkg::ssr_tx_cfg_t tx_cfg_i,
  input  wire ssr_pkg::ssr_rx_evt_t rx_evt_i,
  // Serial link
  input  wire logic                link_clk_i,
  output logic                     tx_data_o,
  output logic                     tx_frame_o,
  output logic                     irq_o
);

  // ***************************************************************
  // Helper functions
  // ***************************************************************

  // Address match against one register
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  // Sticky flag update, a set beats a clear in the same cycle
  function automatic logic sticky(input logic cur,
                                  input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // ***************************************************************
  // Declarations
  // ***************************************************************
  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} ssr_tx_st_t;

  ssr_tx_st_t   tx_st_q;
  logic [31:0]  hold_q;
  logic         hold_full_q;
  logic [31:0]  shift_q;
  logic [15:0]  sync_sh_q;
  logic [4:0]   cnt_q;
  logic [15:0]  tx_sync_word_q;
  logic [15:0]  rx_sync_word_q;
  logic [15:0]  cmp_zero_q;
  logic [15:0]  cmp_one_q;
  logic         wp_on_q;
  logic [31:0]  mask_q;
  logic [31:0]  rd_snap_q;
  logic         rx_avail_q;
  logic         ovwr_q;
  logic         cmp0_q;
  logic         cmp1_q;
  logic         txs_q;
  logic         rxs_q;
  logic         lk_s1_q;
  logic         lk_s2_q;
  logic         lk_s3_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         irq_q;
  logic         tx_data_q;
  logic         tx_frame_q;

  logic [31:0]  status_w;
  logic [31:0]  rdata_w;
  logic         mapped_w;
  logic         capture_w;
  logic         done_w;
  logic         wr_w;
  logic         stat_rd_w;
  logic         lk_fall_w;
  logic         start_w;
  logic         cmp0_hit_w;
  logic         cmp1_hit_w;

  // ***************************************************************
  // Bus phase decode
  // ***************************************************************

  // Capture read data in the first access cycle, finish in the next
  assign capture_w = psel_i & penable_i & ~pready_q;
  assign done_w    = psel_i & penable_i & pready_q;
  assign wr_w      = done_w & pwrite_i;
  assign stat_rd_w = done_w & ~pwrite_i
                   & addr_hit(paddr_i, ssr_pkg::ADDR_STATUS);

  // Address map membership
  always_comb begin
    mapped_w = addr_hit(paddr_i, ssr_pkg::ADDR_TX_HOLD)
             | addr_hit(paddr_i, ssr_pkg::ADDR_RX_SYNC)
             | addr_hit(paddr_i, ssr_pkg::ADDR_TX_SYNC)
             | addr_hit(paddr_i, ssr_pkg::ADDR_CMP_ZERO)
             | addr_hit(paddr_i, ssr_pkg::ADDR_CMP_ONE)
             | addr_hit(paddr_i, ssr_pkg::ADDR_STATUS)
             | addr_hit(paddr_i, ssr_pkg::ADDR_IRQ_SET)
             | addr_hit(paddr_i, ssr_pkg::ADDR_IRQ_CLR)
             | addr_hit(paddr_i, ssr_pkg::ADDR_IRQ_MASK)
             | addr_hit(paddr_i, ssr_pkg::ADDR_WP_MODE);
  end

  // ***************************************************************
  // Status word
  // ***************************************************************

  // Live levels and sticky flags at their bit positions
  always_comb begin
    status_w = ssr_pkg::RST_WORD;
    status_w[ssr_pkg::BIT_TX_FREE]   = ~hold_full_q; // [RQ6]
    status_w[ssr_pkg::BIT_TX_SENT]   = ~hold_full_q
                                     & (tx_st_q == TX_IDLE); // [RQ7]
    status_w[ssr_pkg::BIT_RX_AVAIL]  = rx_avail_q; // [RQ8]
    status_w[ssr_pkg::BIT_RX_OVWR]   = ovwr_q; // [RQ9]
    status_w[ssr_pkg::BIT_CMP_ZERO]  = cmp0_q; // [RQ10]
    status_w[ssr_pkg::BIT_CMP_ONE]   = cmp1_q; // [RQ10]
    status_w[ssr_pkg::BIT_TX_SYNC]   = txs_q; // [RQ11]
    status_w[ssr_pkg::BIT_RX_SYNC]   = rxs_q; // [RQ11]
    status_w[ssr_pkg::BIT_TX_ACTIVE] = tx_active_status_i; // [RQ12]
    status_w[ssr_pkg::BIT_RX_ACTIVE] = rx_active_status_i; // [RQ12]
  end

  // ***************************************************************
  // Read multiplexer
  // ***************************************************************

  // Write-only and unmapped addresses read as zero
  always_comb begin
    rdata_w = ssr_pkg::RST_WORD; // [RQ20]
    if (addr_hit(paddr_i, ssr_pkg::ADDR_RX_SYNC)) begin
      rdata_w[ssr_pkg::SYNC_W-1:0] = rx_sync_word_q; // [RQ2]
    end
    if (addr_hit(paddr_i, ssr_pkg::ADDR_TX_SYNC)) begin
      rdata_w[ssr_pkg::SYNC_W-1:0] = tx_sync_word_q; // [RQ3]
    end
    if (addr_hit(paddr_i, ssr_pkg::ADDR_CMP_ZERO)) begin
      rdata_w[ssr_pkg::SYNC_W-1:0] = cmp_zero_q; // [RQ4]
    end
    if (addr_hit(paddr_i, ssr_pkg::ADDR_CMP_ONE)) begin
      rdata_w[ssr_pkg::SYNC_W-1:0] = cmp_one_q; // [RQ4]
    end
    if (addr_hit(paddr_i, ssr_pkg::ADDR_STATUS)) begin
      rdata_w = status_w;
    end
    if (addr_hit(paddr_i, ssr_pkg::ADDR_IRQ_MASK)) begin
      rdata_w = mask_q; // [RQ15]
    end
    if (addr_hit(paddr_i, ssr_pkg::ADDR_WP_MODE)) begin
      rdata_w[ssr_pkg::WP_ON_BIT] = wp_on_q;
    end
  end

  // ***************************************************************
  // APB answer
  // ***************************************************************

  // One wait state, data and error registered with ready
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= ssr_pkg::RST_WORD;
      pslverr_q <= 1'b0;
      rd_snap_q <= ssr_pkg::RST_WORD;
    end else if (ce_i) begin
      pready_q  <= capture_w;
      if (capture_w) begin
        prdata_q  <= pwrite_i ? ssr_pkg::RST_WORD : rdata_w;
        pslverr_q <= ~mapped_w;
        rd_snap_q <= status_w;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Software written registers
  // ***************************************************************

  // Sync word, compare words, write protection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sync_word_q <= ssr_pkg::RST_HALF;
      cmp_zero_q     <= ssr_pkg::RST_HALF;
      cmp_one_q      <= ssr_pkg::RST_HALF;
      wp_on_q        <= 1'b0;
    end else if (ce_i && wr_w) begin
      if (addr_hit(paddr_i, ssr_pkg::ADDR_TX_SYNC)) begin
        tx_sync_word_q <= pwdata_i[ssr_pkg::SYNC_W-1:0]; // [RQ3]
      end
      if (addr_hit(paddr_i, ssr_pkg::ADDR_CMP_ZERO) && !wp_on_q) begin
        cmp_zero_q <= pwdata_i[ssr_pkg::SYNC_W-1:0]; // [RQ5]
      end
      if (addr_hit(paddr_i, ssr_pkg::ADDR_CMP_ONE) && !wp_on_q) begin
        cmp_one_q <= pwdata_i[ssr_pkg::SYNC_W-1:0]; // [RQ5]
      end
      if (addr_hit(paddr_i, ssr_pkg::ADDR_WP_MODE)
          && pwdata_i[31:ssr_pkg::WP_KEY_LSB] == ssr_pkg::WP_KEY) begin
        wp_on_q <= pwdata_i[ssr_pkg::WP_ON_BIT]; // [RQ18]
      end
    end
  end

  // Interrupt mask, set and clear through separate registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= ssr_pkg::RST_WORD; // [RQ19]
    end else if (ce_i && wr_w) begin
      if (addr_hit(paddr_i, ssr_pkg::ADDR_IRQ_SET)) begin
        mask_q <= mask_q | (pwdata_i & ssr_pkg::SRC_MASK); // [RQ13] [RQ16]
      end else if (addr_hit(paddr_i, ssr_pkg::ADDR_IRQ_CLR)) begin
        mask_q <= mask_q & ~(pwdata_i & ssr_pkg::SRC_MASK); // [RQ14] [RQ16]
      end
    end
  end

  // ***************************************************************
  // Receive side flags
  // ***************************************************************

  assign cmp0_hit_w = rx_evt_i.word_valid
                    & (rx_evt_i.word[ssr_pkg::SYNC_W-1:0] == cmp_zero_q);
  assign cmp1_hit_w = rx_evt_i.word_valid
                    & (rx_evt_i.word[ssr_pkg::SYNC_W-1:0] == cmp_one_q);

  // Sticky flags clear only the bits that the status read returned
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_avail_q <= 1'b0;
      ovwr_q     <= 1'b0;
      cmp0_q     <= 1'b0;
      cmp1_q     <= 1'b0;
      txs_q      <= 1'b0;
      rxs_q      <= 1'b0;
    end else if (ce_i) begin
      rx_avail_q <= sticky(rx_avail_q, rx_evt_i.word_valid,
                           rx_evt_i.holding_read);                   // [RQ8]
      ovwr_q <= sticky(ovwr_q, rx_evt_i.word_valid & rx_avail_q
                       & ~rx_evt_i.holding_read,
                       stat_rd_w & rd_snap_q[ssr_pkg::BIT_RX_OVWR]); // [RQ9]
      cmp0_q <= sticky(cmp0_q, cmp0_hit_w,
                       stat_rd_w & rd_snap_q[ssr_pkg::BIT_CMP_ZERO]); // [RQ10]
      cmp1_q <= sticky(cmp1_q, cmp1_hit_w,
                       stat_rd_w & rd_snap_q[ssr_pkg::BIT_CMP_ONE]); // [RQ10]
      txs_q  <= sticky(txs_q, start_w,
                       stat_rd_w & rd_snap_q[ssr_pkg::BIT_TX_SYNC]); // [RQ11]
      rxs_q  <= sticky(rxs_q, rx_evt_i.sync_event,
                       stat_rd_w & rd_snap_q[ssr_pkg::BIT_RX_SYNC]); // [RQ11]
    end
  end

  // Receive sync word holder, hardware loaded only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sync_word_q <= ssr_pkg::RST_HALF;
    end else if (ce_i && rx_evt_i.sync_valid) begin
      rx_sync_word_q <= rx_evt_i.sync_word; // [RQ2]
    end
  end

  // ***************************************************************
  // Interrupt output
  // ***************************************************************

  // Any enabled source raises the line
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= |(status_w & mask_q & ssr_pkg::SRC_MASK); // [RQ19]
    end
  end

  // ***************************************************************
  // Link clock sampling
  // ***************************************************************

  // Two-stage synchroniser plus an edge stage, reset to the idle high level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lk_s1_q <= 1'b1;
      lk_s2_q <= 1'b1;
      lk_s3_q <= 1'b1;
    end else if (ce_i) begin
      lk_s1_q <= link_clk_i;
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
    end
  end

  assign lk_fall_w = lk_s3_q & ~lk_s2_q;

  // A frame starts on a falling link edge when transmit is enabled and a word waits, from idle or at the end of a data phase
  assign start_w = lk_fall_w & tx_active_status_i & hold_full_q
                 & ((tx_st_q == TX_IDLE)
                 | ((tx_st_q == TX_DATA) & (cnt_q == ssr_pkg::RST_CNT)));

  // ***************************************************************
  // Transmit holding register
  // ***************************************************************

  // A write during the load keeps the register full
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q      <= ssr_pkg::RST_WORD;
      hold_full_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_w && addr_hit(paddr_i, ssr_pkg::ADDR_TX_HOLD)) begin
        hold_q      <= pwdata_i; // [RQ1]
        hold_full_q <= 1'b1; // [RQ6]
      end else if (start_w) begin
        hold_full_q <= 1'b0; // [RQ6]
      end
    end
  end

  // ***************************************************************
  // Transmit shifter
  // ***************************************************************

  // Sync phase, then data phase, shifted on falling link edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_q    <= TX_IDLE;
      shift_q    <= ssr_pkg::RST_WORD;
      sync_sh_q  <= ssr_pkg::RST_HALF;
      cnt_q      <= ssr_pkg::RST_CNT;
      tx_data_q  <= 1'b0;
      tx_frame_q <= 1'b0;
    end else if (ce_i && lk_fall_w) begin
      if (start_w) begin
        tx_st_q    <= TX_SYNC;
        shift_q    <= hold_q; // [RQ1]
        tx_frame_q <= 1'b1;
        tx_data_q  <= tx_cfg_i.sync_pattern_send_enable
                    & tx_sync_word_q[0]; // [RQ17]
        sync_sh_q  <= {1'b0, tx_sync_word_q[15:1]};
        cnt_q      <= {1'b0, tx_cfg_i.sync_len};
      end else begin
        unique case (tx_st_q)
          TX_IDLE: begin
            tx_data_q  <= 1'b0;
            tx_frame_q <= 1'b0;
          end
          TX_SYNC: begin
            if (cnt_q == ssr_pkg::RST_CNT) begin
              tx_st_q    <= TX_DATA;
              tx_frame_q <= 1'b0;
              tx_data_q  <= shift_q[0]; // [RQ1]
              shift_q    <= {1'b0, shift_q[31:1]};
              cnt_q      <= tx_cfg_i.word_length_field;
            end else begin
              tx_data_q  <= tx_cfg_i.sync_pattern_send_enable
                          & sync_sh_q[0]; // [RQ17]
              sync_sh_q  <= {1'b0, sync_sh_q[15:1]};
              cnt_q      <= cnt_q - 5'h01;
            end
          end
          TX_DATA: begin
            if (cnt_q == ssr_pkg::RST_CNT) begin
              tx_st_q   <= TX_IDLE;
              tx_data_q <= 1'b0;
            end else begin
              tx_data_q <= shift_q[0]; // [RQ1]
              shift_q   <= {1'b0, shift_q[31:1]};
              cnt_q     <= cnt_q - 5'h01;
            end
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign prdata_o   = prdata_q;
  assign pready_o   = pready_q;
  assign pslverr_o  = pslverr_q;
  assign irq_o      = irq_q;
  assign tx_data_o  = tx_data_q;
  assign tx_frame_o = tx_frame_q;

endmodule : ssr_regs

`default_nettype wire

// ==== dv/ssr_link_model.sv ====
// Far-side serial receiver: makes the link clock and collects bits
`timescale 1ns/1ps
`default_nettype none
module ssr_link_model (
  input  wire logic   run_i,
  input  wire logic   clear_i,
  input  wire logic   tx_data_i,
  input  wire logic   tx_frame_i,
  output logic        link_clk_o,
  output logic [15:0] sync_o,
  output logic [31:0] data_o
);
  logic seen;
  int   idx;
  // Link clock runs only in a window, idles high
  initial begin
    link_clk_o = 1'b1;
    forever begin
      #80;
      link_clk_o = run_i ? ~link_clk_o : 1'b1;
    end
  end
  // Sample on rising edges
  always @(posedge link_clk_o or posedge clear_i) begin
    if (clear_i) begin
      seen = 1'b0;
      idx = 0;
      sync_o = 16'h0000;
      data_o = 32'h0000_0000;
    end else if (tx_frame_i) begin
      seen = 1'b1;
      sync_o = {tx_data_i, sync_o[15:1]};
    end else if (seen && idx < 32) begin
      data_o[idx] = tx_data_i;
      idx++;
    end
  end
endmodule : ssr_link_model
`default_nettype wire

// ==== dv/ssr_regs_properties.sv ====
// Port-level assertions for the sync serial register slice
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_properties (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic                 pwrite_i,
  input wire logic [31:0]          paddr_i,
  input wire logic [31:0]          pwdata_i,
  input wire logic [31:0]          prdata_o,
  input wire logic                 pready_o,
  input wire logic                 pslverr_o,
  input wire logic                 tx_active_status_i,
  input wire logic                 rx_active_status_i,
  input wire ssr_pkg::ssr_tx_cfg_t tx_cfg_i,
  input wire logic                 tx_data_o,
  input wire logic                 tx_frame_o,
  input wire logic                 irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  logic set_q;
  // Read taken, data due next cycle
  assign rd = psel_i && penable_i && !pready_o && !pwrite_i;
  // Any source enabled since reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) set_q <= 1'b0;
    else if (psel_i && penable_i && pready_o && pwrite_i &&
             paddr_i == ssr_pkg::ADDR_IRQ_SET &&
             (pwdata_i & ssr_pkg::SRC_MASK) != 32'h0) set_q <= 1'b1;
  end
  wo_zero_a: assert property (
    rd && (paddr_i == ssr_pkg::ADDR_TX_HOLD ||
    paddr_i == ssr_pkg::ADDR_IRQ_SET || paddr_i == ssr_pkg::ADDR_IRQ_CLR)
    |=> prdata_o == 32'h0) else $error("write-only read not zero");
  unmapped_err_a: assert property (
    rd && paddr_i == 32'hF001_0050 |=> pready_o && pslverr_o)
    else $error("unmapped read without error");
  rsync_hi_a: assert property (
    rd && paddr_i == ssr_pkg::ADDR_RX_SYNC |=> prdata_o[31:16] == 16'h0)
    else $error("sync holding upper bits set");
  cmp_hi_a: assert property (
    rd && (paddr_i == ssr_pkg::ADDR_CMP_ZERO ||
    paddr_i == ssr_pkg::ADDR_CMP_ONE) |=> prdata_o[31:16] == 16'h0)
    else $error("compare upper bits set");
  live_en_a: assert property (
    rd && paddr_i == ssr_pkg::ADDR_STATUS |=>
    prdata_o[16] == $past(tx_active_status_i) &&
    prdata_o[17] == $past(rx_active_status_i))
    else $error("enable bits wrong");
  stat_bits_a: assert property (
    rd && paddr_i == ssr_pkg::ADDR_STATUS |=>
    (prdata_o & ~32'h0003_0F33) == 32'h0)
    else $error("status reserved bits set");
  mask_bits_a: assert property (
    rd && paddr_i == ssr_pkg::ADDR_IRQ_MASK |=>
    (prdata_o & ~ssr_pkg::SRC_MASK) == 32'h0)
    else $error("mask reserved bits set");
  irq_quiet_a: assert property (
    !set_q |-> !irq_o) else $error("interrupt without enable");
  sync_zero_a: assert property (
    tx_frame_o && !tx_cfg_i.sync_pattern_send_enable |-> !tx_data_o)
    else $error("sync data sent while disabled");
  // Main scenarios reached
  cover property (rd && paddr_i == ssr_pkg::ADDR_STATUS);
  cover property ($rose(irq_o));
  cover property ($rose(tx_frame_o));
endmodule : ssr_regs_properties
bind ssr_regs ssr_regs_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .tx_active_status_i(tx_active_status_i), .tx_cfg_i(tx_cfg_i),
  .rx_active_status_i(rx_active_status_i), .tx_data_o(tx_data_o),
  .tx_frame_o(tx_frame_o), .irq_o(irq_o));
`default_nettype wire

// ==== dv/ssr_regs_test.sv ====
// Self-checking bench for the register slice and its serial output
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic tx_act, rx_act, link_clk, tx_data, tx_frame, irq, run, clr;
  logic [31:0] paddr, pwdata, prdata, rd_val, data_bits;
  logic [15:0] sync_bits;
  ssr_pkg::ssr_tx_cfg_t cfg;
  ssr_pkg::ssr_rx_evt_t evt;
  int num_errors, num_checks;
  ssr_regs DUT (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_active_status_i(tx_act),
    .rx_active_status_i(rx_act), .tx_cfg_i(cfg), .rx_evt_i(evt),
    .link_clk_i(link_clk), .tx_data_o(tx_data), .tx_frame_o(tx_frame),
    .irq_o(irq));
  ssr_link_model u_link (.run_i(run), .clear_i(clr), .tx_data_i(tx_data),
    .tx_frame_i(tx_frame), .link_clk_o(link_clk), .sync_o(sync_bits),
    .data_o(data_bits));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      num_errors++;
      summarize();
    end
    rd_val = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string n, input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0);
    chk(n, exp, rd_val);
  endtask : rd
  // One-cycle receive event
  task automatic ev(input logic v, input logic [31:0] w,
                    input logic h, s, e);
    @(posedge clk);
    evt <= {v, w, h, s, 16'hBEEF, e};
    @(posedge clk);
    evt <= '0;
  endtask : ev
  // Send one word over the link
  task automatic frame(input logic en, input logic [31:0] w,
                       input logic [15:0] s, input logic [31:0] d);
    cfg <= {en, 4'hF, 5'h07};
    clr <= 1'b1;
    wr(ssr_pkg::ADDR_TX_HOLD, w);
    clr <= 1'b0;
    rd("queued", ssr_pkg::ADDR_STATUS, 32'h0003_0000);
    run <= 1'b1;
    repeat (800) @(posedge clk);
    run <= 1'b0;
    chk("sync", {16'h0, s}, {16'h0, sync_bits});
    chk("data", d, data_bits);
    rd("sent", ssr_pkg::ADDR_STATUS, 32'h0003_0403);
  endtask : frame
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, tx_act, rx_act, run, clr} = 7'h00;
    {paddr, pwdata} = 64'h0;
    cfg = '0;
    evt = '0;
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd("status", ssr_pkg::ADDR_STATUS, 32'h0000_0003);
    rd("mask", ssr_pkg::ADDR_IRQ_MASK, 32'h0);
    rd("tx hold", ssr_pkg::ADDR_TX_HOLD, 32'h0);
    rd("irq set", ssr_pkg::ADDR_IRQ_SET, 32'h0);
    rd("irq clr", ssr_pkg::ADDR_IRQ_CLR, 32'h0);
    rd("unmapped", 32'hF001_0050, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    wr(ssr_pkg::ADDR_TX_SYNC, 32'hFFFF_A5C3);
    rd("tsync", ssr_pkg::ADDR_TX_SYNC, 32'h0000_A5C3);
    wr(ssr_pkg::ADDR_CMP_ONE, 32'hFFFF_5678);
    rd("cmp1", ssr_pkg::ADDR_CMP_ONE, 32'h0000_5678);
    wr(ssr_pkg::ADDR_WP_MODE, 32'h0053_5301);
    wr(ssr_pkg::ADDR_CMP_ZERO, 32'h0000_2222);
    rd("cmp0 bad key", ssr_pkg::ADDR_CMP_ZERO, 32'h2222);
    wr(ssr_pkg::ADDR_WP_MODE, {ssr_pkg::WP_KEY, 8'h01});
    wr(ssr_pkg::ADDR_CMP_ZERO, 32'h0000_5555);
    rd("cmp0 locked", ssr_pkg::ADDR_CMP_ZERO, 32'h2222);
    wr(ssr_pkg::ADDR_WP_MODE, {ssr_pkg::WP_KEY, 8'h00});
    wr(ssr_pkg::ADDR_CMP_ZERO, 32'h0000_1234);
    rd("cmp0 open", ssr_pkg::ADDR_CMP_ZERO, 32'h1234);
    ev(1'b0, 32'h0, 1'b0, 1'b1, 1'b0);
    wr(ssr_pkg::ADDR_RX_SYNC, 32'hFFFF_FFFF);
    rd("rsync", ssr_pkg::ADDR_RX_SYNC, 32'h0000_BEEF);
    $display("test registers done");
    wr(ssr_pkg::ADDR_IRQ_SET, 32'hFFFF_FFFF);
    rd("mask all", ssr_pkg::ADDR_IRQ_MASK, ssr_pkg::SRC_MASK);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ssr_pkg::ADDR_IRQ_CLR, 32'h0000_0F00);
    wr(ssr_pkg::ADDR_IRQ_SET, 32'h0);
    wr(ssr_pkg::ADDR_IRQ_MASK, 32'h0);
    rd("mask part", ssr_pkg::ADDR_IRQ_MASK, 32'h0000_0033);
    wr(ssr_pkg::ADDR_IRQ_CLR, ssr_pkg::SRC_MASK);
    rd("mask none", ssr_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test mask done");
    tx_act <= 1'b1;
    rx_act <= 1'b1;
    ev(1'b1, 32'h0000_1234, 1'b0, 1'b0, 1'b0);
    ev(1'b1, 32'hABCD_5678, 1'b0, 1'b0, 1'b1);
    rd("status ev", ssr_pkg::ADDR_STATUS, 32'h0003_0B33);
    rd("status clr", ssr_pkg::ADDR_STATUS, 32'h0003_0013);
    ev(1'b0, 32'h0, 1'b1, 1'b0, 1'b0);
    rd("status rd", ssr_pkg::ADDR_STATUS, 32'h0003_0003);
    $display("test status done");
    frame(1'b1, 32'hFFFF_FF96, 16'hA5C3, 32'h96);
    frame(1'b0, 32'h0000_0005, 16'h0, 32'h5);
    $display("test link done");
    summarize();
  end
endmodule : ssr_regs_test
`default_nettype wire
